// ===== hw/siw_sleep_idle_wake_control.sv
// sleep, idle and wake sequencing for the cpu core
`timescale 1ns/100ps
module siw_sleep_idle_wake_control
  import siw_pkg::*;
#(
  parameter int IRQ_N      = 8,
  parameter int CSW_IDX    = 1,
  parameter int OST_CYC    = SIW_OST_PERIODS,
  parameter int LP_CYC     = SIW_LP_WAKE_CYC
) (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  // register port
  input  wire logic [3:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rdata_out,
  // cpu core
  input  wire logic              sleep_exec_in,
  input  wire logic [15:0]       pc_in,
  input  wire logic              global_irq_enable_in,
  input  wire logic              isr_entry_in,
  output logic                   cpu_halt_out,
  output logic                   prefetch_req_out,
  output logic      [15:0]       prefetch_addr_out,
  output logic                   isr_call_out,
  output logic      [15:0]       isr_vector_out,
  output logic                   doze_active_out,
  // interrupt sources
  input  wire logic [IRQ_N-1:0]  irq_flag_in,
  input  wire logic [IRQ_N-1:0]  irq_enable_in,
  // reset and watchdog sources
  input  wire logic              external_reset_pin_in,
  input  wire logic              external_reset_en_in,
  input  wire logic              brownout_reset_in,
  input  wire logic              brownout_reset_en_in,
  input  wire logic              power_on_reset_in,
  input  wire logic              watchdog_timer_in,
  input  wire logic              watchdog_timer_en_in,
  output logic                   device_reset_out,
  output logic                   watchdog_clear_out,
  // clocks and regulator
  input  wire logic [1:0]        osc_mode_in,
  input  wire logic              clock_output_en_in,
  output logic                   fosc_periph_run_out,
  output logic                   internal_osc_mode_periph_run_out,
  output logic                   clock_output_run_out,
  output logic                   core_regulator_lowpower_out
);

  typedef struct packed {
    siw_state_e  state;
    logic [11:0] cnt;
    logic        wake_irq;
    logic [7:0]  rdata;
    logic        lp_sel;
    logic        idle_sel;
    logic        doze;
    logic        recover_on_irq;
    logic        pwrdown;
    logic        timeout;
    logic        halt;
    logic        fosc_run;
    logic        internal_osc_mode_run;
    logic        reg_lp;
    logic        dev_rst;
    logic        wdt_clr;
    logic        prefetch;
    logic [15:0] pf_addr;
    logic        isr_call;
    logic        clock_output_pin_run;
    logic [15:0] isr_vec;
  } siw_state_s;

  siw_state_s r;
  siw_state_s next_r;

  // enabled and flagged sources, optionally without the clock switch source
  function automatic logic any_irq(input logic [IRQ_N-1:0] fl, input logic [IRQ_N-1:0] en,
                                   input logic skip_csw);
    logic [IRQ_N-1:0] m;
    m = fl & en;
    if (skip_csw) begin
      m[CSW_IDX] = 1'b0;
    end
    return |m;
  endfunction

  logic irq_wake;
  logic irq_pending;
  logic rst_event;
  logic wdt_event;
  logic xtal_mode;

  // wake source decode
  assign irq_wake    = any_irq(irq_flag_in, irq_enable_in, 1'b0);
  assign irq_pending = !global_irq_enable_in
                       && any_irq(irq_flag_in, irq_enable_in, 1'b1);
  assign rst_event   = (external_reset_pin_in && external_reset_en_in)
                       || (brownout_reset_in && brownout_reset_en_in)
                       || power_on_reset_in;
  assign wdt_event   = watchdog_timer_in && watchdog_timer_en_in;
  assign xtal_mode   = (osc_mode_in != SIW_OSC_EXT_CLK) && (osc_mode_in != SIW_OSC_INTERNAL);

  // next state and register logic
  always_comb begin
    next_r          = r;
    next_r.dev_rst  = 1'b0;
    next_r.wdt_clr  = 1'b0;
    next_r.prefetch = 1'b0;
    next_r.isr_call = 1'b0;
    next_r.rdata    = 8'h00;
    // register writes
    if (wr_in) begin
      if (addr_in == SIW_REG_REGULATOR) begin
        next_r.lp_sel = wdata_in[SIW_BIT_LP_SEL];
      end else if (addr_in == SIW_REG_CPUCTRL) begin
        next_r.idle_sel = wdata_in[SIW_BIT_IDLE_SEL];
        next_r.doze     = wdata_in[SIW_BIT_DOZE];
        next_r.recover_on_irq      = wdata_in[SIW_BIT_ROI];
      end
    end
    // isr entry returns to full speed when recover-on-irq is set
    if (isr_entry_in && r.recover_on_irq) begin
      next_r.doze = 1'b0;
    end
    case (r.state)
      SIW_RUN: begin
        if (sleep_exec_in) begin
          next_r.prefetch = 1'b1;
          next_r.pf_addr  = pc_in + 16'h0001;
          if (!irq_pending) begin
            next_r.wdt_clr = 1'b1;
            next_r.pwrdown = 1'b0;
            next_r.timeout = 1'b1;
            next_r.state   = r.idle_sel ? SIW_IDLE : SIW_SLEEP;
          end
        end
      end
      SIW_SLEEP: begin
        // the cpu clock is stopped; these sources are watched here
        if (rst_event) begin
          next_r.dev_rst = 1'b1;
          next_r.wdt_clr = 1'b1;
          next_r.state   = SIW_RUN;
        end else if (wdt_event || irq_wake) begin
          next_r.wdt_clr  = 1'b1;
          next_r.wake_irq = irq_wake && !wdt_event;
          next_r.cnt      = (xtal_mode ? 12'(OST_CYC) : 12'h000)
                            + (r.lp_sel ? 12'(LP_CYC) : 12'h000);
          next_r.state    = SIW_WAKE;
        end
      end
      SIW_IDLE: begin
        if (rst_event) begin
          next_r.dev_rst = 1'b1;
          next_r.state   = SIW_RUN;
        end else if (irq_wake) begin
          if (r.recover_on_irq && r.doze) begin
            next_r.doze = 1'b0;
          end
          next_r.wake_irq = 1'b1;
          next_r.cnt      = 12'h000;
          next_r.state    = SIW_WAKE;
        end else if (wdt_event) begin
          next_r.wake_irq = 1'b0;
          next_r.cnt      = 12'h000;
          next_r.state    = SIW_WAKE;
        end
      end
      SIW_WAKE: begin
        // hold the cpu until start-up and regulator delays run out
        if (r.cnt == 12'h000) begin
          next_r.state    = SIW_RUN;
          next_r.isr_call = r.wake_irq && global_irq_enable_in;
          next_r.wake_irq = 1'b0;
        end else begin
          next_r.cnt = r.cnt - 12'h001;
        end
      end
      default: begin
        next_r.state = SIW_RUN;
      end
    endcase
    // mode driven outputs follow the next state
    next_r.halt       = (next_r.state != SIW_RUN);
    next_r.fosc_run   = (next_r.state != SIW_SLEEP);
    next_r.internal_osc_mode_run = 1'b1;
    next_r.clock_output_pin_run = clock_output_en_in && (next_r.state != SIW_SLEEP);
    next_r.reg_lp     = r.lp_sel && (next_r.state == SIW_SLEEP);
    // register reads, data one cycle later
    if (rd_in) begin
      if (addr_in == SIW_REG_REGULATOR) begin
        next_r.rdata[SIW_BIT_LP_SEL]  = r.lp_sel;
        next_r.rdata[SIW_BIT_REG_ONE] = 1'b1;
      end else if (addr_in == SIW_REG_CPUCTRL) begin
        next_r.rdata[SIW_BIT_IDLE_SEL] = r.idle_sel;
        next_r.rdata[SIW_BIT_DOZE]     = r.doze;
        next_r.rdata[SIW_BIT_ROI]      = r.recover_on_irq;
      end else if (addr_in == SIW_REG_STATUS) begin
        next_r.rdata[SIW_BIT_TIMEOUT] = r.timeout;
        next_r.rdata[SIW_BIT_PWRDOWN] = r.pwrdown;
        next_r.rdata[2:0]             = r.state;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r            <= '0;
      r.state      <= SIW_RUN;
      r.lp_sel     <= SIW_RST_LP_SEL;
      r.pwrdown    <= SIW_RST_FLAG;
      r.timeout    <= SIW_RST_FLAG;
      r.fosc_run   <= 1'b1;
      r.internal_osc_mode_run <= 1'b1;
      r.isr_vec    <= SIW_ISR_VECTOR;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign rdata_out                   = r.rdata;
  assign cpu_halt_out                = r.halt;
  assign prefetch_req_out            = r.prefetch;
  assign prefetch_addr_out           = r.pf_addr;
  assign isr_call_out                = r.isr_call;
  assign isr_vector_out              = r.isr_vec;
  assign doze_active_out             = r.doze;
  assign device_reset_out            = r.dev_rst;
  assign watchdog_clear_out          = r.wdt_clr;
  assign fosc_periph_run_out         = r.fosc_run;
  assign internal_osc_mode_periph_run_out       = r.internal_osc_mode_run;
  assign clock_output_run_out        = r.clock_output_pin_run;
  assign core_regulator_lowpower_out = r.reg_lp;

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  sequence s_sleep_req;
    r.state == SIW_RUN && sleep_exec_in && !wr_in;
  endsequence
  sequence s_sleep_irq_wake;
    r.state == SIW_SLEEP && irq_wake && !wdt_event && !rst_event;
  endsequence

  chk_nop_keeps_flags: assert property (
    s_sleep_req and (irq_pending && r.pwrdown)
    |=> r.state == SIW_RUN && r.pwrdown && !watchdog_clear_out)
    else $error("pending irq did not turn sleep into a no-op");
  chk_sleep_entry: assert property (
    s_sleep_req and (!irq_pending && !r.idle_sel)
    |=> r.state == SIW_SLEEP && !r.pwrdown && r.timeout && watchdog_clear_out && cpu_halt_out)
    else $error("sleep entry did not update flags and watchdog");
  chk_idle_entry: assert property (
    s_sleep_req and (!irq_pending && r.idle_sel)
    |=> r.state == SIW_IDLE && cpu_halt_out && fosc_periph_run_out)
    else $error("idle entry wrong");
  chk_wake_wdt_clear: assert property (
    (r.state == SIW_SLEEP && (irq_wake || wdt_event || rst_event)) |=> watchdog_clear_out)
    else $error("watchdog not cleared on wake");
  chk_reset_wake: assert property (
    (r.state == SIW_SLEEP && power_on_reset_in) |=> device_reset_out && !cpu_halt_out)
    else $error("reset wake did not reset");
  chk_sleep_clocks: assert property (
    (r.state == SIW_SLEEP) |-> !fosc_periph_run_out && internal_osc_mode_periph_run_out && cpu_halt_out)
    else $error("clock gating wrong in sleep");
  chk_lp_wake_delay: assert property (
    (s_sleep_irq_wake and (r.lp_sel && !xtal_mode)) |=> cpu_halt_out [*8])
    else $error("low-power wake released too early");
  chk_normal_wake: assert property (
    (s_sleep_irq_wake and (!r.lp_sel && !xtal_mode)) |=> ##1 !cpu_halt_out)
    else $error("normal wake not quick");
  chk_idle_roi: assert property (
    (r.state == SIW_IDLE && irq_wake && r.recover_on_irq && r.doze && !rst_event && !isr_entry_in
     && !wr_in) |=> !r.doze && !device_reset_out)
    else $error("recover on irq did not restore speed");
  chk_idle_wdt: assert property (
    (r.state == SIW_IDLE && wdt_event && !irq_wake && !rst_event && !wr_in && !isr_entry_in)
    |=> !device_reset_out && $stable(r.doze) ##1 !cpu_halt_out && !isr_call_out)
    else $error("watchdog in idle misbehaved");

  // release, vector and mode output checks
  chk_prefetch_addr: assert property (
    (r.state == SIW_RUN && sleep_exec_in)
    |=> prefetch_req_out && prefetch_addr_out == $past(pc_in) + 16'h0001)
    else $error("prefetch address wrong");
  chk_isr_call: assert property (
    (r.state == SIW_WAKE && r.cnt == 12'h000 && r.wake_irq && global_irq_enable_in)
    |=> isr_call_out && !cpu_halt_out && isr_vector_out == SIW_ISR_VECTOR)
    else $error("isr call after irq wake missing");
  chk_wake_hold: assert property (
    (r.state == SIW_WAKE && r.cnt != 12'h000) |=> cpu_halt_out && r.state == SIW_WAKE)
    else $error("cpu released before wake delay ran out");
  chk_idle_keeps_sel: assert property (
    (r.state == SIW_IDLE && irq_wake && !rst_event && !wr_in) |=> $stable(r.idle_sel) && cpu_halt_out)
    else $error("idle select lost on irq wake");
  chk_idle_reset: assert property (
    (r.state == SIW_IDLE && rst_event) |=> device_reset_out && !cpu_halt_out)
    else $error("reset source in idle did not reset");
  chk_sleep_regulator: assert property (
    $stable(r.lp_sel) |-> core_regulator_lowpower_out == (r.lp_sel && r.state == SIW_SLEEP))
    else $error("regulator low-power state wrong");
  chk_idle_clocks: assert property (
    (r.state == SIW_IDLE) |-> fosc_periph_run_out && internal_osc_mode_periph_run_out
                              && clock_output_run_out == $past(clock_output_en_in))
    else $error("clock gating wrong in idle");
  chk_doze_isr: assert property (
    (isr_entry_in && r.recover_on_irq) |=> !doze_active_out)
    else $error("isr entry did not clear doze");

endmodule

// ===== hw/siw_pkg.sv
// constants and types for the sleep, idle and wake controller
package siw_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] SIW_REG_REGULATOR = 4'h0;
  localparam logic [3:0] SIW_REG_CPUCTRL   = 4'h1;
  localparam logic [3:0] SIW_REG_STATUS    = 4'h2;
  // field positions
  localparam int SIW_BIT_LP_SEL   = 1;
  localparam int SIW_BIT_REG_ONE  = 0;
  localparam int SIW_BIT_IDLE_SEL = 7;
  localparam int SIW_BIT_DOZE     = 6;
  localparam int SIW_BIT_ROI      = 5;
  localparam int SIW_BIT_TIMEOUT  = 4;
  localparam int SIW_BIT_PWRDOWN  = 3;
  // reset values
  localparam logic SIW_RST_LP_SEL  = 1'b0;
  localparam logic SIW_RST_FLAG    = 1'b1;
  // fixed interrupt vector
  localparam logic [15:0] SIW_ISR_VECTOR = 16'h0004;
  // oscillator start-up delay in oscillator periods
  localparam int SIW_OST_PERIODS = 1024;
  // regulator recovery time and system clock period
  localparam int SIW_LP_WAKE_NS = 2000;
  localparam int SIW_CLK_PS     = 5000;
  localparam int SIW_LP_WAKE_CYC = (SIW_LP_WAKE_NS * 1000 + SIW_CLK_PS - 1) / SIW_CLK_PS;
  // oscillator mode encoding
  localparam logic [1:0] SIW_OSC_EXT_CLK = 2'h0;
  localparam logic [1:0] SIW_OSC_INTERNAL = 2'h1;
  // controller states
  typedef enum logic [2:0] {
    SIW_RUN   = 3'b000,
    SIW_SLEEP = 3'b001,
    SIW_IDLE  = 3'b010,
    SIW_WAKE  = 3'b011
  } siw_state_e;
endpackage

// ===== tb/siw_cpu_model.sv
// cpu core model issuing sleep instructions and entering the isr
`timescale 1ns/100ps
module siw_cpu_model (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  // bench request
  input  wire logic        go_in,
  input  wire logic [15:0] pc_val_in,
  // controller side
  input  wire logic        cpu_halt_in,
  input  wire logic        isr_call_in,
  output logic             sleep_exec_out,
  output logic      [15:0] pc_out,
  output logic             isr_entry_out
);
  // sleep issued only while running; pc changes every cycle when unqualified
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sleep_exec_out <= 1'b0;
      pc_out         <= 16'h0000;
      isr_entry_out  <= 1'b0;
    end else begin
      sleep_exec_out <= go_in && !cpu_halt_in;
      pc_out         <= go_in ? pc_val_in : ~pc_out;
      isr_entry_out  <= isr_call_in;
    end
  end
endmodule

// ===== tb/sleep_idle_wake_control_tb.sv
// self-checking bench for the sleep, idle and wake controller
`timescale 1ns/100ps
module sleep_idle_wake_control_tb;
  import siw_pkg::*;
  localparam int OST = 4;
  localparam int LP  = 8;
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, wr = 1'b0, rd = 1'b0, global_irq_enable = 1'b0, go = 1'b0;
  logic xr = 1'b0, xr_en = 1'b0, bor = 1'b0, bor_en = 1'b0, por = 1'b0, wdt = 1'b0;
  logic wdt_en = 1'b0, ck_en = 1'b1, sx, ie, halt, pf, ic, dz, drst, wclr, frun, irun, crun, rlp;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, flag = 8'h00, en = 8'h00, rdata;
  logic [1:0] osc = 2'h0;
  logic [15:0] pcv = 16'h0000, pc, pfa, vec;
  logic [31:0] lf = 32'h0001_3341;
  int fail_count = 0, checks = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  siw_sleep_idle_wake_control #(.OST_CYC(OST), .LP_CYC(LP)) u_dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sleep_exec_in(sx), .pc_in(pc),
    .global_irq_enable_in(global_irq_enable), .isr_entry_in(ie), .cpu_halt_out(halt),
    .prefetch_req_out(pf), .prefetch_addr_out(pfa), .isr_call_out(ic),
    .isr_vector_out(vec), .doze_active_out(dz), .irq_flag_in(flag), .irq_enable_in(en),
    .external_reset_pin_in(xr), .external_reset_en_in(xr_en), .brownout_reset_in(bor),
    .brownout_reset_en_in(bor_en), .power_on_reset_in(por), .watchdog_timer_in(wdt),
    .watchdog_timer_en_in(wdt_en), .device_reset_out(drst), .watchdog_clear_out(wclr),
    .osc_mode_in(osc), .clock_output_en_in(ck_en), .fosc_periph_run_out(frun),
    .internal_osc_mode_periph_run_out(irun), .clock_output_run_out(crun),
    .core_regulator_lowpower_out(rlp));

  siw_cpu_model u_cpu (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .go_in(go), .pc_val_in(pcv),
    .cpu_halt_in(halt), .isr_call_in(ic), .sleep_exec_out(sx), .pc_out(pc),
    .isr_entry_out(ie));

  // pseudo-random source
  function automatic logic [15:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[15:0];
  endfunction
  // cycles from wake event to halt release
  function automatic int wake_cyc(input logic [1:0] o, input logic l);
    return 2 + (o[1] ? OST : 0) + (l ? LP : 0);
  endfunction

  task automatic stop_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // sleep instruction through the cpu model
  task automatic sleep_op(input logic pend);
    logic [15:0] p;
    p = rnd();
    @(posedge clk_sys_in);
    go <= 1'b1; pcv <= p;
    @(posedge clk_sys_in);
    go <= 1'b0;
    @(posedge clk_sys_in);
    #1 chk(pf, 1'b1);
    chk(pfa, p + 16'h0001);
    chk(wclr, !pend);
    chk(halt, !pend);
  endtask
  // wait for halt release after a wake source was raised at the last edge
  task automatic wait_wake(input int en_n, input logic e_rst, input logic e_isr, input logic cc);
    int n, clr;
    logic rs;
    n = 0; clr = 0; rs = 1'b0;
    while (halt === 1'b1 && n < 2000) begin
      @(posedge clk_sys_in);
      #1 n++;
      clr += (wclr === 1'b1);
      rs |= (drst === 1'b1);
    end
    if (n >= 2000) begin
      fail_count++;
      stop_test();
    end else begin
      if (en_n >= 0) chk(16'(n), 16'(en_n));
      chk(rs, e_rst);
      if (!e_rst) chk(ic, e_isr);
      if (cc) chk(16'(clr), 16'h0001);
    end
  endtask
  task automatic hold_check();
    repeat (4) @(posedge clk_sys_in);
    #1 chk(halt, 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd_chk(SIW_REG_REGULATOR, 8'h01);
    rd_chk(SIW_REG_STATUS, 8'h18);
    rd_chk(SIW_REG_CPUCTRL, 8'h00);
    rd_chk(4'hB, 8'h00);
    wr_reg(SIW_REG_STATUS, 8'hE7);
    rd_chk(SIW_REG_STATUS, 8'h18);
    chk(vec, SIW_ISR_VECTOR);
    chk(irun, 1'b1);
    // pending enabled irq with global enable clear turns sleep into a no-op
    en <= 8'hFF; flag <= 8'h01;
    sleep_op(1'b1);
    rd_chk(SIW_REG_STATUS, 8'h18);
    // clock switch source alone is not pending
    flag <= 8'h02;
    sleep_op(1'b0);
    @(posedge clk_sys_in);
    flag <= 8'h00;
    wait_wake(-1, 1'b0, 1'b0, 1'b0);
    // every oscillator mode, both regulator modes, both global enables
    for (int m = 0; m < 8; m++) begin
      osc <= 2'(m); global_irq_enable <= m[0];
      wr_reg(SIW_REG_REGULATOR, {6'h00, m[2], 1'b1});
      en <= (8'(rnd()) & 8'hF5) | 8'h04;
      sleep_op(1'b0);
      rd_chk(SIW_REG_STATUS, 8'h11);
      chk(rlp, m[2]);
      chk(frun, 1'b0);
      chk(crun, 1'b0);
      flag <= 8'h08;
      hold_check();
      flag <= 8'h0C;
      wait_wake(wake_cyc(2'(m), m[2]), 1'b0, m[0], 1'b1);
      flag <= 8'h00;
    end
    // watchdog wake from sleep continues execution
    osc <= 2'h0; global_irq_enable <= 1'b1; wdt_en <= 1'b1;
    wr_reg(SIW_REG_REGULATOR, 8'h01);
    sleep_op(1'b0);
    wdt <= 1'b1;
    wait_wake(2, 1'b0, 1'b0, 1'b1);
    wdt <= 1'b0;
    // reset-type wakes, disabled pin first
    for (int s = 0; s < 3; s++) begin
      sleep_op(1'b0);
      xr <= (s == 0);
      hold_check();
      xr_en <= (s == 0); bor <= (s == 1); bor_en <= (s == 1); por <= (s == 2);
      wait_wake(-1, 1'b1, 1'b0, 1'b0);
      xr <= 1'b0; xr_en <= 1'b0; bor <= 1'b0; bor_en <= 1'b0; por <= 1'b0;
    end
    // idle with doze and recover-on-irq
    wr_reg(SIW_REG_CPUCTRL, 8'hE0);
    sleep_op(1'b0);
    rd_chk(SIW_REG_STATUS, 8'h12);
    chk(frun, 1'b1);
    chk(crun, 1'b1);
    ck_en <= 1'b0;
    @(posedge clk_sys_in);
    #1 chk(crun, 1'b0);
    ck_en <= 1'b1;
    chk(rlp, 1'b0);
    wdt <= 1'b1;
    wait_wake(2, 1'b0, 1'b0, 1'b0);
    wdt <= 1'b0;
    rd_chk(SIW_REG_CPUCTRL, 8'hE0);
    sleep_op(1'b0);
    flag <= 8'h04;
    wait_wake(2, 1'b0, 1'b1, 1'b0);
    flag <= 8'h00;
    repeat (3) @(posedge clk_sys_in);
    rd_chk(SIW_REG_CPUCTRL, 8'hA0);
    chk(dz, 1'b0);
    // reset source while idle resets the device
    sleep_op(1'b0);
    por <= 1'b1;
    wait_wake(-1, 1'b1, 1'b0, 1'b0);
    por <= 1'b0;
    stop_test();
  end
endmodule
